// File: rtl/aacs_core.sv
// Four-phase datapath for add-with-carry, and-literal and literal-minus-acc, APB slave
//
// Decided for this implementation: the register addresses and the APB register port.
module aacs_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import aacs_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_Q1,
    ST_Q2,
    ST_Q3,
    ST_Q4
  } aacs_state_t;

  aacs_state_t state;
  logic ext_en;
  logic [INSN_W-1:0] insn;
  logic [DATA_W-1:0] acc;
  aacs_flags_t flags;
  logic [BANK_W-1:0] bank_select_reg;
  logic [MEM_AW-1:0] index_base;
  logic [MEM_AW-1:0] mem_addr;
  logic bad_op;
  aacs_op_t op;
  logic dest_file;
  logic [MEM_AW-1:0] eff_addr;
  logic [DATA_W-1:0] operand;
  aacs_alu_t result;
  logic [1:0] read_step;
  logic [DATA_W-1:0] ram_rdata;
  logic ram_rd;
  logic ram_wr;
  logic [MEM_AW-1:0] ram_addr;
  logic [DATA_W-1:0] ram_wdata;
  logic access;
  logic mapped;
  logic wr_fire;
  logic [31:0] read_mux;
  aacs_op_t next_op;
  logic [MEM_AW-1:0] next_eff_addr;
  aacs_alu_t next_result;

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic

  function automatic aacs_alu_t add8(input logic [7:0] a, input logic [7:0] b, input logic cin);
    aacs_alu_t r;
    logic [8:0] sum;
    logic [4:0] low;
    sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    r.res = sum[7:0];
    r.flags.c = sum[8];
    r.flags.low_nibble_out_bit = low[4];
    r.flags.z = (sum[7:0] == 8'h00);
    r.flags.n = sum[7];
    // Same-sign operands giving opposite-sign result
    r.flags.signed_error_flag = (a[7] == b[7]) && (sum[7] != a[7]);
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  assign access = psel && penable;
  assign wr_fire = access && pwrite && pready;

  always_comb begin
    unique case (paddr)
      REG_CTRL, REG_INSN, REG_ACC, REG_STATUS, REG_BANKSEL,
      REG_INDEX_BASE, REG_MEM_ADDR, REG_MEM_DATA, REG_EXEC: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Everything waits while an instruction is in flight; reads take three cycles
  // so that prdata comes from a flop even for the memory window.
  always_comb begin
    if (state != ST_IDLE) begin
      pready = 1'b0;
    end else if (pwrite) begin
      pready = 1'b1;
    end else begin
      pready = (read_step == READ_LAST_STEP);
    end
  end

  assign pslverr = access && pready && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_step <= 2'h0;
    end else if (access && !pwrite && state == ST_IDLE) begin
      read_step <= pready ? 2'h0 : read_step + 2'h1;
    end else begin
      read_step <= 2'h0;
    end
  end

  always_comb begin
    read_mux = 32'h0000_0000;
    unique case (paddr)
      REG_CTRL: read_mux[CTRL_EXT_EN_BIT] = ext_en;
      REG_INSN: read_mux[INSN_W-1:0] = insn;
      REG_ACC: read_mux[DATA_W-1:0] = acc;
      REG_STATUS: read_mux[$bits(aacs_flags_t)-1:0] = flags;
      REG_BANKSEL: read_mux[BANK_W-1:0] = bank_select_reg;
      REG_INDEX_BASE: read_mux[MEM_AW-1:0] = index_base;
      REG_MEM_ADDR: read_mux[MEM_AW-1:0] = mem_addr;
      REG_MEM_DATA: read_mux[DATA_W-1:0] = ram_rdata;
      REG_EXEC: begin
        read_mux[EXEC_BUSY_BIT] = (state != ST_IDLE);
        read_mux[EXEC_BAD_OP_BIT] = bad_op;
      end
      default: read_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (access && !pwrite && read_step == 2'h1) begin
      prdata <= read_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-held registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_en <= 1'b0;
    end else if (wr_fire && paddr == REG_CTRL) begin
      ext_en <= pwdata[CTRL_EXT_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_select_reg <= BANKSEL_RESET;
    end else if (wr_fire && paddr == REG_BANKSEL) begin
      bank_select_reg <= pwdata[BANK_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_base <= INDEX_BASE_RESET;
    end else if (wr_fire && paddr == REG_INDEX_BASE) begin
      index_base <= pwdata[MEM_AW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_addr <= '0;
    end else if (wr_fire && paddr == REG_MEM_ADDR) begin
      mem_addr <= pwdata[MEM_AW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      insn <= INSN_RESET;
    end else if (wr_fire && paddr == REG_INSN) begin
      insn <= pwdata[INSN_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction cycle: one phase per clock

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: if (wr_fire && paddr == REG_INSN) state <= ST_Q1;
        ST_Q1: state <= ST_Q2;
        ST_Q2: state <= ST_Q3;
        ST_Q3: state <= ST_Q4;
        ST_Q4: state <= ST_IDLE;
      endcase
    end
  end

  // Q1 decode
  always_comb begin
    if (insn[15:10] == OPC_ADD_WITH_CARRY_TO_FILE) begin
      next_op = OP_ADDC;
    end else if (insn[15:8] == OPC_AND_LITERAL_INTO_ACC) begin
      next_op = OP_ANDL;
    end else if (insn[15:8] == OPC_LITERAL_MINUS_ACC) begin
      next_op = OP_SUBL;
    end else begin
      next_op = OP_BAD;
    end
    if (!insn[INSN_BANK_BIT] && ext_en && insn[7:0] <= ACCESS_LOW_TOP) begin
      next_eff_addr = index_base + {4'h0, insn[7:0]};
    end else if (!insn[INSN_BANK_BIT]) begin
      next_eff_addr = (insn[7:0] <= ACCESS_LOW_TOP) ? {4'h0, insn[7:0]}
                                                    : {ACCESS_HIGH_BANK, insn[7:0]};
    end else begin
      next_eff_addr = {bank_select_reg, insn[7:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op <= OP_BAD;
      eff_addr <= '0;
      dest_file <= 1'b0;
    end else if (state == ST_Q1) begin
      op <= next_op;
      eff_addr <= next_eff_addr;
      dest_file <= insn[INSN_DEST_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bad_op <= 1'b0;
    end else if (state == ST_Q1) begin
      bad_op <= (next_op == OP_BAD);
    end
  end

  // Q2 read: literal latched here, file byte arrives from the memory at Q3
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      operand <= 8'h00;
    end else if (state == ST_Q2) begin
      operand <= insn[7:0];
    end
  end

  // Q3 process
  always_comb begin
    next_result.res = acc;
    next_result.flags = flags;
    unique case (op)
      OP_ADDC: next_result = add8(acc, ram_rdata, flags.c);
      OP_ANDL: begin
        next_result.res = acc & operand;
        next_result.flags.z = ((acc & operand) == 8'h00);
        next_result.flags.n = (acc[7] & operand[7]);
      end
      // Literal plus inverted acc plus one: carry means no borrow
      OP_SUBL: next_result = add8(operand, ~acc, 1'b1);
      OP_BAD: next_result.res = acc;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= '0;
    end else if (state == ST_Q3) begin
      result <= next_result;
    end
  end

  // Q4 write destination
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= ACC_RESET;
    end else if (state == ST_Q4 && op != OP_BAD && !(op == OP_ADDC && dest_file)) begin
      acc <= result.res;
    end else if (wr_fire && paddr == REG_ACC) begin
      acc <= pwdata[DATA_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags <= FLAGS_RESET;
    end else if (state == ST_Q4 && op != OP_BAD) begin
      flags <= result.flags;
    end else if (wr_fire && paddr == REG_STATUS) begin
      flags <= pwdata[$bits(aacs_flags_t)-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data memory, shared by software window and the datapath

  // Software is stalled during Q1..Q4, so the two users never collide.
  always_comb begin
    ram_rd = 1'b0;
    ram_wr = 1'b0;
    ram_addr = mem_addr;
    ram_wdata = pwdata[DATA_W-1:0];
    if (state == ST_Q2) begin
      ram_rd = (op == OP_ADDC);
      ram_addr = eff_addr;
    end else if (state == ST_Q4) begin
      ram_wr = (op == OP_ADDC) && dest_file;
      ram_addr = eff_addr;
      ram_wdata = result.res;
    end else begin
      ram_rd = access && !pwrite && paddr == REG_MEM_DATA && read_step == 2'h0;
      ram_wr = wr_fire && paddr == REG_MEM_DATA;
    end
  end

  aacs_data_ram #(
    .DW(DATA_W),
    .AW(MEM_AW)
  ) u_ram (
    .clk(pclk),
    .rst_n(presetn),
    .rd_en(ram_rd),
    .wr_en(ram_wr),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

endmodule

// File: rtl/aacs_data_ram.sv
// Byte-wide data memory with registered read data
module aacs_data_ram #(
  parameter int DW = 8,
  parameter int AW = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (rd_en) begin
      rdata <= mem[addr];
    end
  end

endmodule

// File: rtl/aacs_pkg.sv
// Shared constants, register map and types of the add/and/subtract datapath
package aacs_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INSN = 8'h04;
  localparam logic [7:0] REG_ACC = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_BANKSEL = 8'h10;
  localparam logic [7:0] REG_INDEX_BASE = 8'h14;
  localparam logic [7:0] REG_MEM_ADDR = 8'h18;
  localparam logic [7:0] REG_MEM_DATA = 8'h1C;
  localparam logic [7:0] REG_EXEC = 8'h20;

  // Field positions
  localparam int CTRL_EXT_EN_BIT = 0;
  localparam int EXEC_BUSY_BIT = 0;
  localparam int EXEC_BAD_OP_BIT = 1;
  localparam int INSN_DEST_BIT = 9;
  localparam int INSN_BANK_BIT = 8;

  // Widths
  localparam int DATA_W = 8;
  localparam int BANK_W = 4;
  localparam int MEM_AW = 12;
  localparam int INSN_W = 16;

  // Opcode fields
  localparam logic [5:0] OPC_ADD_WITH_CARRY_TO_FILE = 6'b0010_00;
  localparam logic [7:0] OPC_AND_LITERAL_INTO_ACC = 8'h0B;
  localparam logic [7:0] OPC_LITERAL_MINUS_ACC = 8'h08;

  // Addressing constants
  localparam logic [7:0] ACCESS_LOW_TOP = 8'h5F;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

  // Reset values
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [3:0] BANKSEL_RESET = 4'h0;
  localparam logic [11:0] INDEX_BASE_RESET = 12'h000;
  localparam logic [15:0] INSN_RESET = 16'h0000;

  // Read wait steps before pready on a read
  localparam logic [1:0] READ_LAST_STEP = 2'h2;

  typedef struct packed {
    logic n;
    logic signed_error_flag;
    logic z;
    logic low_nibble_out_bit;
    logic c;
  } aacs_flags_t;

  localparam aacs_flags_t FLAGS_RESET = '0;

  typedef struct packed {
    logic [7:0] res;
    aacs_flags_t flags;
  } aacs_alu_t;

  typedef enum logic [1:0] {
    OP_ADDC,
    OP_ANDL,
    OP_SUBL,
    OP_BAD
  } aacs_op_t;

endpackage

// File: test/aacs_apb_model.sv
// APB master standing in for the fetch and decode side
module aacs_apb_model (
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // Ends on the completing edge with the request still up, so back to back needs no release
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Read at the edge itself: values are still those the core sees before its flops move
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
  endtask
endmodule

// File: test/aacs_core_props.sv
// Port-level timing checks of the datapath core
module aacs_core_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  import aacs_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire live = psel && penable;
  wire done = live && pready;
  wire insn_wr = done && pwrite && paddr == REG_INSN;
  // A finished plain transfer leaves the core idle
  wire plain = done && paddr != REG_INSN;
  //////////////////////////////////////////////////////////////////////////////
  a_err_needs_ready: assert property (live && pslverr |-> pready)
    else $error("error flag without ready");
  a_unmapped_err: assert property (done && paddr > REG_EXEC |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (done && paddr <= REG_EXEC && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access flagged as error");
  a_read_waits: assert property (psel && !penable && !pwrite |=> !pready [*2])
    else $error("read answered too early");
  a_read_third: assert property (plain ##1 (psel && !penable && !pwrite) ##1 live [*3] |-> pready)
    else $error("idle read not answered in third access cycle");
  a_idle_write: assert property (plain ##1 (psel && !penable && pwrite) |=> pready)
    else $error("idle write not answered at once");
  a_insn_busy: assert property (insn_wr |=> !pready [*4])
    else $error("access answered during instruction phases");
  a_insn_done: assert property (insn_wr ##1 (psel && pwrite) [*4] ##1 (live && pwrite) |-> pready)
    else $error("instruction cycle longer than four clocks");
  a_rdata_hold: assert property ($changed(prdata) |-> $past(live) && !$past(pwrite))
    else $error("read data changed without a read");
endmodule

bind aacs_core aacs_core_props u_aacs_core_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr);

// File: test/tb_top.sv
// Self-checking bench of the add/and/subtract datapath core
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import aacs_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  int miscompares, checks_done, cyc;
  aacs_core u_aacs_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr);
  aacs_apb_model u_aacs_apb_model (.pclk, .pready, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      miscompares++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_aacs_apb_model.xfer(1'b1, a, {16'h0000, d}, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    u_aacs_apb_model.xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, {16'h0000, e});
  endtask
  task automatic poke(input logic [15:0] a, input logic [15:0] d);
    wr(REG_MEM_ADDR, a);
    wr(REG_MEM_DATA, d);
  endtask
  // The ignored REG_EXEC write right behind the instruction starts its setup in Q1 and stalls through Q2..Q4
  task automatic run(input logic [15:0] a, s, i, ea, es);
    wr(REG_ACC, a);
    wr(REG_STATUS, s);
    wr(REG_INSN, i);
    wr(REG_EXEC, 16'h0003);
    rd(REG_ACC, ea);
    rd(REG_STATUS, es);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(REG_ACC, 16'h0000);
    rd(REG_STATUS, 16'h0000);
    $display("test reset done");
    run(16'h00A3, 16'h000B, 16'h0B5F, 16'h0003, 16'h000B);
    run(16'h0080, 16'h0005, 16'h0BFF, 16'h0080, 16'h0011);
    run(16'h00F0, 16'h0010, 16'h0B0F, 16'h0000, 16'h0004);
    run(16'h0001, 16'h0000, 16'h0802, 16'h0001, 16'h0003);
    run(16'h0002, 16'h0000, 16'h0802, 16'h0000, 16'h0007);
    run(16'h0003, 16'h001F, 16'h0802, 16'h00FF, 16'h0010);
    run(16'h0001, 16'h0000, 16'h0880, 16'h007F, 16'h0009);
    $display("test literal ops done");
    run(16'h0055, 16'h0003, 16'h2455, 16'h0055, 16'h0003);
    rd(REG_EXEC, 16'h0002);
    poke(16'h0234, 16'h0002);
    wr(REG_BANKSEL, 16'h0002);
    run(16'h004D, 16'h0001, 16'h2134, 16'h0050, 16'h0002);
    rd(REG_EXEC, 16'h0000);
    poke(16'h0050, 16'h0080);
    run(16'h0080, 16'h0000, 16'h2250, 16'h0080, 16'h000D);
    rd(REG_MEM_DATA, 16'h0000);
    wr(REG_CTRL, 16'h0001);
    chk(32'(pslverr), 32'h0000_0000);
    wr(REG_INDEX_BASE, 16'h0300);
    poke(16'h035F, 16'h0011);
    run(16'h0022, 16'h0001, 16'h205F, 16'h0034, 16'h0000);
    poke(16'h0F60, 16'h007F);
    run(16'h0001, 16'h0000, 16'h2060, 16'h0080, 16'h001A);
    rd(REG_CTRL, 16'h0001);
    rd(REG_INDEX_BASE, 16'h0300);
    rd(REG_BANKSEL, 16'h0002);
    rd(REG_MEM_ADDR, 16'h0F60);
    rd(REG_INSN, 16'h2060);
    $display("test add with carry done");
    wr(8'h24, 16'h1234);
    chk(32'(pslverr), 32'h0000_0001);
    rd(8'h24, 16'h0000);
    $display("test unmapped done");
    end_sim();
  end
endmodule
